// ===== bench/dpsp_pcm_model.sv
`timescale 1ns/100ps
`default_nettype none
// codec side; the bit clock stands still between frames
module dpsp_pcm_model (
  input wire logic [1:0] park_i, // strobe levels between frames
  output logic bclk_o,
  output logic lstb_o,
  output logic astb_o,
  output logic ldin_o,
  output logic adin_o,
  input wire logic ldout_i,
  input wire logic loe_i,
  input wire logic adout_i,
  input wire logic aoe_i
);
  logic busy; // high while a frame is clocked
  logic st_l; // line strobe inside a frame
  logic st_a; // acoustic strobe inside a frame
  assign lstb_o = busy ? st_l : park_i[0];
  assign astb_o = busy ? st_a : park_i[1];
  initial begin
    busy = 0;
    st_l = 0;
    st_a = 0;
    bclk_o = 0;
    ldin_o = 0;
    adin_o = 0;
  end
  // one frame of 18 bit clocks, strobes from bit 0, msb first
  task automatic frame(input int nl, na, input logic [15:0] lw, aw,
                       output logic [15:0] lo, ao, output logic bad);
    lo = '0;
    ao = '0;
    bad = 0;
    busy = 1;
    for (int b = 0; b < 18; b++) begin
      #20;
      // strobe moves mid low half, well before the rise
      st_l = b < nl;
      st_a = b < na;
      // a line outside its window shows no stale bit
      ldin_o = st_l ? lw[nl-1-b] : ~ldin_o;
      adin_o = st_a ? aw[na-1-b] : ~adin_o;
      #20 bclk_o = 1;
      #30;
      if (st_l) lo = {lo[14:0], ldout_i};
      if (st_a) ao = {ao[14:0], adout_i};
      bad |= (loe_i !== st_l) || (aoe_i !== st_a);
      #10 bclk_o = 0;
    end
    busy = 0;
  endtask
endmodule
`default_nettype wire

// ===== bench/dpsp_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dpsp_tb_top;
  import dpsp_pkg::*;
  logic clk, rst, psel, pen, pwr, ev, bad, frm, lmd, amd, law, sty;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr;
  wire logic bclk, lstb, astb, rin, sin;
  logic sout, soe, rout, roe;
  logic [1:0] park; // strobe pins outside frames
  logic [15:0] x, lo, ao;
  logic [15:0] q[$]; // line words in flight
  int error_cnt, checks_done, cyc;
  dpsp_top #(.IDLE_CYC_P(200), .FIFO_DEPTH(16)) dut_u (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SERIAL_BIT_CLOCK_I(bclk), .FRAME_ALIGN_PULSE_I(frm),
    .LINE_PORT_STROBE_I(lstb), .LINE_PORT_SUBMODE_I(lmd),
    .ACOUSTIC_PORT_STROBE_I(astb), .ACOUSTIC_PORT_SUBMODE_I(amd),
    .RECV_IN_I(rin), .SEND_IN_I(sin), .LAW_SEL_I(law),
    .CODE_STYLE_I(sty), .SEND_OUT_O(sout), .SEND_OUT_OE_O(soe),
    .RECV_OUT_O(rout), .RECV_OUT_OE_O(roe));
  dpsp_pcm_model m_u (.park_i(park), .bclk_o(bclk), .lstb_o(lstb),
    .astb_o(astb), .ldin_o(rin), .adin_o(sin), .ldout_i(sout),
    .loe_i(soe), .adout_i(rout), .aoe_i(roe));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // fixed-seed lfsr, sixteen bits
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // speaker code sent while the buffer is empty
  function automatic logic [15:0] idle(input logic a, s);
    return s ? (a ? MASK_A : MASK_MU) : 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // no count of its own: only the run timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // pins stay put 10 cycles after release so submodes latch
  task automatic rst_seq;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    logic [15:0] gw[3], ge[3];
    logic [3:0] gi[3];
    gi = '{4'hf, 4'hf, 4'h0};
    gw = '{16'h4000, 16'hc000, 16'h4000};
    ge = '{LIN_MAX, LIN_MIN, 16'h0408};
    {psel, pen, pwr, paddr, pwdata, frm, lmd, amd, law, sty} = '0;
    park = 0;
    rst = 1;
    x = 16'h0050;
    error_cnt = 0;
    checks_done = 0;
    rst_seq;
    apb(0, ADDR_CTRL, 0);
    chk("ctrl_reset", 32'h08, rv);
    apb(0, ADDR_STAT, 0);
    chk("stat_reset", 32'h40, rv);
    apb(0, 8'h0c, 0);
    chk("unmapped", 32'h1, {rv[30:0], ev});
    apb(1, ADDR_CTRL, 32'h7f);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl_rw", 32'h7f, rv);
    apb(1, ADDR_CTRL, 32'h08);
    $display("registers done");
    // every law and code style on the idle speaker code
    for (int i = 0; i < 4; i++) begin
      law <= i[0];
      sty <= i[1];
      x = lfsr(x);
      m_u.frame(0, 8, 0, x, lo, ao, bad);
      chk("rout_idle", idle(i[0], i[1]), ao);
      chk("oe_window", 0, bad);
    end
    $display("code styles done");
    // linear 0 db: overfill the speaker buffer, then drain it
    law <= 0;
    sty <= 0;
    apb(1, ADDR_CTRL, 32'h38);
    for (int i = 0; i < 19; i++) begin
      x = lfsr(x);
      q.push_back(x);
      m_u.frame(16, 0, x, 0, lo, ao, bad);
    end
    // buffer, gain stage and hold word fill up; the 19th word
    // overwrites the 18th while it still waits
    q.delete(17);
    apb(0, ADDR_STAT, 0);
    chk("lost_set", 1, rv[STA_OVR]);
    apb(1, ADDR_STAT, 32'h20);
    apb(0, ADDR_STAT, 0);
    chk("lost_clr", 0, rv[STA_OVR]);
    // sixteen buffered, one in the gain stage, one waiting
    for (int i = 0; i < 18; i++) begin
      m_u.frame(0, 16, 0, 0, lo, ao, bad);
      chk("rout_lin", {16'h0, q[i]}, {16'h0, ao});
      chk("oe_window", 0, bad);
    end
    apb(0, ADDR_STAT, 0);
    chk("drained", 1, rv[STA_EMPTY]);
    $display("buffer done");
    // gain ends and saturation
    for (int i = 0; i < 3; i++) begin
      apb(1, ADDR_CTRL, {26'h0, 2'h3, gi[i]});
      m_u.frame(16, 0, gw[i], 0, lo, ao, bad);
      m_u.frame(0, 16, 0, 0, lo, ao, bad);
      chk("gain", {16'h0, ge[i]}, {16'h0, ao});
    end
    $display("gain done");
    // line linear, acoustic companded
    apb(1, ADDR_CTRL, 32'h18);
    m_u.frame(0, 8, 0, 16'h00a5, lo, ao, bad);
    m_u.frame(16, 0, 0, 0, lo, ao, bad);
    chk("mixed", 32'ha500, {16'h0, lo});
    $display("mixed done");
    // submodes latched at release, then framed entry and exit
    // mode pins leave low only while the frame pin runs
    frm <= 1;
    lmd <= 1;
    park <= 2'b10;
    rst_seq;
    apb(0, ADDR_STAT, 0);
    chk("submode", 32'h56, rv);
    repeat (8) @(posedge clk);
    apb(0, ADDR_STAT, 0);
    chk("framed", 1, rv[STA_MODE]);
    frm <= 0;
    lmd <= 0;
    park <= 0;
    repeat (250) @(posedge clk);
    apb(0, ADDR_STAT, 0);
    chk("strobe_mode", 0, rv[STA_MODE]);
    $display("modes done");
    complete_run;
  end
endmodule
`default_nettype wire

// ===== rtl/dpsp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dpsp_fifo
  import dpsp_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // pointers wrap naturally, so depth must be a power of two
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // word storage
    logic [AW-1:0] wp; // write index
    logic [AW-1:0] rp; // read index
    logic [AW:0] cnt; // words held
  } dpsp_fifo_s;

  dpsp_fifo_s q;
  dpsp_fifo_s d;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];

  // next state: push and pop may happen together
  always_comb begin
    d = q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  full_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_valid_i && !in_ready_o && !out_ready_i |=> q.cnt == $past(q.cnt))
    else $error("fifo took a word while full");
endmodule
`default_nettype wire

// ===== rtl/dpsp_gain.sv
`timescale 1ns/100ps
`default_nettype none
module dpsp_gain
  import dpsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WORD_W-1:0] in_data_i,
  input wire logic bypass_i,
  input wire logic [GAIN_IDX_W-1:0] idx_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WORD_W-1:0] out_data_o
);
  typedef struct packed {
    logic v; // output word held
    logic [WORD_W-1:0] data; // scaled word
  } dpsp_gain_s;

  dpsp_gain_s q;
  dpsp_gain_s d;
  logic signed [32:0] prod;
  logic signed [20:0] scaled;
  logic [WORD_W-1:0] sat;

  // one stage skid: accept whenever the held word leaves
  assign in_ready_o = !q.v || out_ready_i;
  assign out_valid_o = q.v;
  assign out_data_o = q.data;

  // multiply, drop the fraction and clip to the linear range
  always_comb begin
    d = q;
    prod = $signed(in_data_i) * $signed({1'b0, GAIN_TAB[idx_i]});
    scaled = prod[32:GAIN_FRAC];
    if (scaled[20:15] == '0 || scaled[20:15] == '1) begin
      sat = scaled[15:0];
    end else begin
      sat = scaled[20] ? LIN_MIN : LIN_MAX; // clipping beats wrap noise
    end
    if (in_valid_i && in_ready_o) begin
      d.v = 1'b1;
      d.data = bypass_i ? in_data_i : sat; // companded codes pass as is
    end else if (out_ready_i) begin
      d.v = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  gain_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_valid_i && in_ready_o && bypass_i
      |=> out_valid_o && out_data_o == $past(in_data_i))
    else $error("bypassed word altered by gain stage");
endmodule
`default_nettype wire

// ===== rtl/dpsp_pkg.sv
package dpsp_pkg;
  // core clock rate and audio frame period
  localparam int CLK_MHZ = 200;
  localparam int FRAME_US = 125;
  // frame pin held low this long means strobe-gated mode
  localparam int IDLE_US = 2 * FRAME_US;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int IDLE_W = 16;
  // positions inside the pin synchroniser vector
  localparam int SY_BCLK = 0;
  localparam int SY_FRM = 1;
  localparam int SY_STB0 = 2;
  localparam int SY_STB1 = 3;
  localparam int SY_MD0 = 4;
  localparam int SY_MD1 = 5;
  localparam int SY_DIN0 = 6;
  localparam int SY_DIN1 = 7;
  localparam int SY_LAW = 8;
  localparam int SY_FMT = 9;
  localparam int SY_N = 10;
  // serial word layout: companded codes ride in the upper byte
  localparam int WORD_W = 16;
  localparam int CMP_W = 8;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] CMP_LAST = 4'h7;
  localparam logic [IDX_W-1:0] LIN_LAST = 4'hf;
  localparam int FCNT_W = 9;
  localparam int SLOT_BITS = 8;
  localparam int SUB_W = 2;
  localparam int BOOT_W = 2;
  localparam logic [BOOT_W-1:0] BOOT_DONE = 2'h3;
  // bit inversion masks of the standard code style
  localparam logic [CMP_W-1:0] MASK_A = 8'h55;
  localparam logic [CMP_W-1:0] MASK_MU = 8'h7f;
  // speaker gain, -24 db .. +21 db in 3 db steps, q12 coefficients
  localparam int GAIN_IDX_W = 4;
  localparam int GAIN_N = 16;
  localparam int GAIN_FRAC = 12;
  localparam logic [15:0] GAIN_TAB [GAIN_N] = '{
    16'h0102, 16'h016c, 16'h0202, 16'h02d6,
    16'h0401, 16'h05aa, 16'h0805, 16'h0b54,
    16'h1000, 16'h169a, 16'h1fed, 16'h2d18,
    16'h3fb2, 16'h59f9, 16'h7f15, 16'hb384};
  localparam logic [WORD_W-1:0] LIN_MAX = 16'h7fff;
  localparam logic [WORD_W-1:0] LIN_MIN = 16'h8000;
  // apb register map
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STAT = 8'h04;
  localparam int CT_GAIN = 0;
  localparam int CT_LIN0 = 4;
  localparam int CT_LIN1 = 5;
  localparam int CT_GCI = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h08;
  localparam int STA_SUB0 = 0;
  localparam int STA_SUB1 = 2;
  localparam int STA_MODE = 4;
  localparam int STA_OVR = 5;
  localparam int STA_EMPTY = 6;

  // port timing mode
  typedef enum logic {
    MODE_STROBE = 1'b0,
    MODE_FRAMED = 1'b1
  } dpsp_mode_e;

  // per-port serial state
  typedef struct packed {
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] tx_sh;
    logic [IDX_W-1:0] idx;
    logic out;
    logic oe;
    logic [SUB_W-1:0] submode;
  } dpsp_port_s;

  // code style: the standard code inverts bits of sign-magnitude
  function automatic logic [CMP_W-1:0] dpsp_style(
    input logic [CMP_W-1:0] c,
    input logic a_law,
    input logic g711
  );
    logic [CMP_W-1:0] m;
    m = a_law ? MASK_A : MASK_MU;
    return g711 ? (c ^ m) : c;
  endfunction
endpackage

// ===== rtl/dpsp_top.sv
// Overview of operation
// - line port moves bits only under strobe or in its framed slot
// - acoustic port moves bits only under strobe or in its framed slot
// - line strobe and mode pins pick submode
// - acoustic strobe and mode pins pick submode
// - inputs take 128 to 4096 kbit/s streams
// - each port has its own sample format
// - law select low mu-law, high a-law
// - style select low sign-magnitude, high standard
// - samples cross safely into core clock
// - speaker gain -24 to +21 db, 3 db, when the line port is linear
// - frame pin tied low selects strobe mode
// - reset holds device in quiet standby
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dpsp_top
  import dpsp_pkg::*;
#(
  parameter int unsigned IDLE_CYC_P = IDLE_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [APB_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SERIAL_BIT_CLOCK_I,
  input wire logic FRAME_ALIGN_PULSE_I,
  input wire logic LINE_PORT_STROBE_I,
  input wire logic LINE_PORT_SUBMODE_I,
  input wire logic ACOUSTIC_PORT_STROBE_I,
  input wire logic ACOUSTIC_PORT_SUBMODE_I,
  input wire logic RECV_IN_I,
  input wire logic SEND_IN_I,
  input wire logic LAW_SEL_I,
  input wire logic CODE_STYLE_I,
  output logic SEND_OUT_O,
  output logic SEND_OUT_OE_O,
  output logic RECV_OUT_O,
  output logic RECV_OUT_OE_O
);
  // all block state in one record
  typedef struct packed {
    logic [SY_N-1:0] sync1; // first stage, read by sync2 only
    logic [SY_N-1:0] sync2; // settled pin levels
    logic bclk_prev; // bit clock one cycle ago
    logic frm_prev; // frame pin one cycle ago
    dpsp_mode_e mode; // strobe-gated or framed
    logic [IDLE_W-1:0] idle_cnt; // cycles the frame pin sat low
    logic [FCNT_W-1:0] fcnt; // bit position in a framed frame
    dpsp_port_s [1:0] port; // 0 line side, 1 acoustic side
    logic pend_v; // line word waiting for the gain stage
    logic [WORD_W-1:0] pend_w; // that word
    logic [WORD_W-1:0] xsrc; // acoustic word for the send output
    logic [CTRL_W-1:0] ctrl; // software control
    logic ovr; // sticky: line word lost
    logic latched; // submodes captured
    logic [BOOT_W-1:0] boot; // settle delay after reset
    logic [31:0] prdata; // apb read data
    logic pready; // apb access answer
    logic pslverr; // apb unmapped address
  } dpsp_state_s;

  dpsp_state_s st_q;
  dpsp_state_s st_d;

  logic rise; // bit clock rising edge seen
  logic fall; // bit clock falling edge seen
  logic frm_on; // frame pulse at its active level
  logic [1:0] act; // port window open
  logic [1:0] done; // port word completed this cycle
  logic [WORD_W-1:0] rxw [2]; // completed words
  logic [IDX_W-1:0] last; // final bit index of a word
  logic [FCNT_W-1:0] start; // first bit of a framed slot
  logic [WORD_W-1:0] w; // word to send
  logic lin; // port carries linear samples
  logic fifo_pop; // acoustic port takes a word
  logic [1:0] sel; // apb decode

  // speaker path wires
  logic g_ready;
  logic g_valid;
  logic [WORD_W-1:0] g_data;
  logic f_ready;
  logic f_valid;
  logic [WORD_W-1:0] f_data;

  // one-hot register decode, used for reads and writes
  function automatic logic [1:0] reg_sel(
    input logic [APB_AW-1:0] a
  );
    reg_sel = {a == ADDR_STAT, a == ADDR_CTRL};
  endfunction

  // gain on the speaker path, bypassed for companded codes
  dpsp_gain u_gain (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(st_q.pend_v),
    .in_ready_o(g_ready),
    .in_data_i(st_q.pend_w),
    .bypass_i(!st_q.ctrl[CT_LIN0]),
    .idx_i(st_q.ctrl[CT_GAIN +: GAIN_IDX_W]),
    .out_valid_o(g_valid),
    .out_ready_i(f_ready),
    .out_data_o(g_data)
  );

  // buffer between line receive and speaker output
  dpsp_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(g_valid),
    .in_ready_o(f_ready),
    .in_data_i(g_data),
    .out_valid_o(f_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(f_data)
  );

  // next-state logic
  always_comb begin
    st_d = st_q;
    fifo_pop = 1'b0;
    done = '0;
    act = '0;
    rxw[0] = '0;
    rxw[1] = '0;
    last = CMP_LAST;
    start = '0;
    w = '0;
    lin = 1'b0;
    sel = reg_sel(PADDR_I);
    // every serial-side pin passes two flops before use; apb pins do not
    st_d.sync1 = {CODE_STYLE_I, LAW_SEL_I, SEND_IN_I, RECV_IN_I,
                  ACOUSTIC_PORT_SUBMODE_I, LINE_PORT_SUBMODE_I,
                  ACOUSTIC_PORT_STROBE_I, LINE_PORT_STROBE_I,
                  FRAME_ALIGN_PULSE_I, SERIAL_BIT_CLOCK_I};
    st_d.sync2 = st_q.sync1;
    st_d.bclk_prev = st_q.sync2[SY_BCLK];
    st_d.frm_prev = st_q.sync2[SY_FRM];
    rise = st_q.sync2[SY_BCLK] && !st_q.bclk_prev;
    fall = !st_q.sync2[SY_BCLK] && st_q.bclk_prev;
    // gci pulse is active high, the other framed mode active low
    frm_on = st_q.ctrl[CT_GCI] ? st_q.sync2[SY_FRM] : !st_q.sync2[SY_FRM];

    // a pin that never rises is tied low: strobe-gated mode
    if (st_q.sync2[SY_FRM]) begin
      st_d.idle_cnt = '0;
      if (!st_q.frm_prev) begin
        st_d.mode = MODE_FRAMED;
      end
    end else if (st_q.idle_cnt != IDLE_W'(IDLE_CYC_P)) begin
      st_d.idle_cnt = st_q.idle_cnt + 1'b1;
    end else begin
      st_d.mode = MODE_STROBE;
    end

    // framed bit counter restarts on the frame pulse
    if (fall) begin
      st_d.fcnt = frm_on ? '0 : st_q.fcnt + 1'b1;
    end

    // catch submodes once the synchroniser has settled
    if (!st_q.latched) begin
      st_d.boot = st_q.boot + 1'b1;
      if (st_q.boot == BOOT_DONE) begin
        st_d.latched = 1'b1;
        st_d.port[0].submode = {st_q.sync2[SY_MD0],
                                st_q.sync2[SY_STB0]};
        st_d.port[1].submode = {st_q.sync2[SY_MD1],
                                st_q.sync2[SY_STB1]};
      end
    end

    // both ports run the same serial engine
    for (int p = 0; p < 2; p++) begin
      lin = st_q.ctrl[CT_LIN0 + p];
      last = lin ? LIN_LAST : CMP_LAST;
      start = FCNT_W'(st_q.port[p].submode) * FCNT_W'(SLOT_BITS);
      case (st_q.mode)
        MODE_STROBE: act[p] = st_q.sync2[SY_STB0 + p];
        MODE_FRAMED: act[p] = st_q.fcnt >= start &&
                              st_q.fcnt <= start + FCNT_W'(last);
        default: act[p] = 1'b0;
      endcase
      // send side: load on the first rising edge, then shift
      if (rise) begin
        if (act[p]) begin
          if (st_q.port[p].idx == '0) begin
            if (p == 0) begin
              w = st_q.xsrc;
            end else begin
              w = f_valid ? f_data : '0; // idle on empty buffer
              fifo_pop = f_valid;
            end
            if (!lin) begin
              w = {dpsp_style(w[WORD_W-1 -: CMP_W], st_q.sync2[SY_LAW],
                   st_q.sync2[SY_FMT]), {CMP_W{1'b0}}};
            end
          end else begin
            w = st_q.port[p].tx_sh;
          end
          st_d.port[p].out = w[WORD_W-1];
          st_d.port[p].tx_sh = w << 1;
          st_d.port[p].oe = 1'b1;
        end else begin
          st_d.port[p].out = 1'b0;
          st_d.port[p].oe = 1'b0; // release the shared line
        end
      end
      // receive side: sample on the falling edge
      if (fall) begin
        if (act[p]) begin
          st_d.port[p].rx_sh = {st_q.port[p].rx_sh[WORD_W-2:0],
                                st_q.sync2[SY_DIN0 + p]};
          if (st_q.port[p].idx == last) begin
            done[p] = 1'b1;
            st_d.port[p].idx = '0;
          end else begin
            st_d.port[p].idx = st_q.port[p].idx + 1'b1;
          end
        end else begin
          st_d.port[p].idx = '0; // short strobe drops the word
        end
      end
      rxw[p] = lin ? st_d.port[p].rx_sh :
               {dpsp_style(st_d.port[p].rx_sh[CMP_W-1:0],
                st_q.sync2[SY_LAW], st_q.sync2[SY_FMT]),
                {CMP_W{1'b0}}};
    end

    // line word hands over to the gain stage
    if (st_q.pend_v && g_ready) begin
      st_d.pend_v = 1'b0;
    end
    // w1c on the lost-word flag; a new loss below wins
    if (PSEL_I && PENABLE_I && st_q.pready && PWRITE_I &&
        sel[1] && PWDATA_I[STA_OVR]) begin
      st_d.ovr = 1'b0;
    end
    if (done[0]) begin
      if (st_q.pend_v && !g_ready) begin
        st_d.ovr = 1'b1; // back-pressure reached the port
      end
      st_d.pend_v = 1'b1;
      st_d.pend_w = rxw[0];
    end
    // microphone word goes straight to the send output
    if (done[1]) begin
      st_d.xsrc = rxw[1];
    end

    // apb: answer in the first access cycle
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (PSEL_I && !PENABLE_I) begin
      st_d.pready = 1'b1;
      st_d.prdata = '0;
      case (sel)
        2'h1: st_d.prdata[CTRL_W-1:0] = st_q.ctrl;
        2'h2: begin
          st_d.prdata[STA_SUB0 +: SUB_W] = st_q.port[0].submode;
          st_d.prdata[STA_SUB1 +: SUB_W] = st_q.port[1].submode;
          st_d.prdata[STA_MODE] = st_q.mode;
          st_d.prdata[STA_OVR] = st_q.ovr;
          st_d.prdata[STA_EMPTY] = !f_valid;
        end
        default: st_d.pslverr = 1'b1; // unmapped reads zero
      endcase
    end
    if (PSEL_I && PENABLE_I && st_q.pready && PWRITE_I && sel[0]) begin
      st_d.ctrl = PWDATA_I[CTRL_W-1:0];
    end
  end

  // state register; reset keeps both outputs released
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flops
  assign PRDATA_O = st_q.prdata;
  assign PREADY_O = st_q.pready;
  assign PSLVERR_O = st_q.pslverr;
  assign SEND_OUT_O = st_q.port[0].out;
  assign SEND_OUT_OE_O = st_q.port[0].oe;
  assign RECV_OUT_O = st_q.port[1].out;
  assign RECV_OUT_OE_O = st_q.port[1].oe;

  line_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(st_q.port[0].rx_sh) |-> $past(act[0] && fall))
    else $error("line port sampled outside its window");

  acou_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(st_q.port[1].rx_sh) |-> $past(act[1] && fall))
    else $error("acoustic port sampled outside its window");

  line_sub_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(st_q.latched) |-> st_q.port[0].submode ==
      $past({st_q.sync2[SY_MD0], st_q.sync2[SY_STB0]}))
    else $error("line submode not taken from pins");

  acou_sub_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(st_q.latched) |-> st_q.port[1].submode ==
      $past({st_q.sync2[SY_MD1], st_q.sync2[SY_STB1]}))
    else $error("acoustic submode not taken from pins");

  sub_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_q.latched |=> $stable(st_q.port[0].submode) &&
      $stable(st_q.port[1].submode))
    else $error("submode changed after latch");

  frame_detect_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !st_q.sync2[SY_FRM] && st_q.idle_cnt == IDLE_W'(IDLE_CYC_P)
      |=> st_q.mode == MODE_STROBE)
    else $error("tied-low frame pin did not select strobe mode");

  code_style_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    done[1] && !st_q.ctrl[CT_LIN1] |=> st_q.xsrc[WORD_W-1 -: CMP_W] ==
      dpsp_style($past(st_q.port[1].rx_sh[CMP_W-2:0]) << 1 |
        CMP_W'($past(st_q.sync2[SY_DIN1])),
        $past(st_q.sync2[SY_LAW]), $past(st_q.sync2[SY_FMT])))
    else $error("companded code style mismatch");

  standby_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $past(RST_I) |-> !SEND_OUT_OE_O && !RECV_OUT_OE_O)
    else $error("output driven straight after reset");

  apb_ready_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O || !PENABLE_I)
    else $error("apb answer not one access cycle");
endmodule
`default_nettype wire
